/* loop_watchdog_pkg.sv */
package loop_watchdog_pkg;

  localparam logic [15:0] MODE_ADDR        = 16'hff98;
  localparam logic [15:0] CLEAR_KEY_ADDR   = 16'hff99;
  localparam logic [7:0]  MODE_RESET       = 8'h67;
  localparam logic [7:0]  CLEAR_KEY_READ   = 8'h9a;
  localparam logic [7:0]  CLEAR_KEY_VALUE  = 8'hac;
  localparam logic [2:0]  MODE_FIXED_HIGH  = 3'h3;
  localparam int          CLOCK_STOP_POS   = 4;
  localparam int          CLOCK_SRC_POS    = 3;
  localparam int          INTERVAL_MSB     = 2;
  localparam int          OSC_BASE_EXP     = 11;
  localparam int          X1_BASE_EXP      = 13;
  localparam int          CNT_W            = 21;
  localparam int          CAUSE_BIT_POS    = 4;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef struct packed {
    logic        osc_run;
    logic        x1_run;
    logic        standby;
  } clk_stat_t;

endpackage : loop_watchdog_pkg

/* loop_detect_watchdog.sv */
`timescale 1ns/1ps
module loop_detect_watchdog
  import loop_watchdog_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic                        osc_stoppable_opt,
  input  wire loop_watchdog_pkg::bus_req_t  bus_req,
  input  wire loop_watchdog_pkg::clk_stat_t clk_stat,
  input  wire logic                        osc_tick,
  input  wire logic                        x1_tick,
  input  wire logic                        cause_clear,
  output logic [7:0]                       rdata,
  output logic                             bus_wait,
  output logic                             internal_reset,
  output logic [7:0]                       reset_cause_register
);
  import loop_watchdog_pkg::*;

  typedef struct packed {
    logic                 opt_valid;
    logic                 stoppable;
    logic [7:0]           mode;
    logic                 mode_written;
    logic                 stopped;
    logic [CNT_WIDTH-1:0] count;
    logic                 pending;
    logic                 sys_reset;
    logic                 cause_flag;
    logic                 wait_pend;
    logic [7:0]           rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  localparam int INTERVAL_CODES = 1 << (INTERVAL_MSB + 1);

  logic                 stoppable_eff;
  logic                 use_x1;
  logic                 src_tick;
  logic                 src_running;
  logic                 mode_hit;
  logic                 key_hit;
  logic                 mode_wr;
  logic                 mode_rd;
  logic                 key_wr;
  logic                 key_rd;
  logic                 mode_again;
  logic                 mode_bit;
  logic                 key_bad_value;
  logic                 key_bit;
  logic                 violation;
  logic                 stop_request;
  logic                 count_step;
  logic                 count_wrap;
  logic                 fire_now;
  logic                 fire_later;
  logic                 fire_pending;
  logic [7:0]           read_value;
  logic [7:0]           mode_stoppable_wr;
  logic [7:0]           mode_fixed_wr;
  logic [CNT_WIDTH-1:0] count_inc;
  logic [CNT_WIDTH-1:0] limit;
  logic [CNT_WIDTH-1:0] osc_limit [INTERVAL_CODES];
  logic [CNT_WIDTH-1:0] x1_limit  [INTERVAL_CODES];

  overflow_limit_table #(
    .CNT_WIDTH (CNT_WIDTH),
    .BASE_EXP  (OSC_BASE_EXP),
    .CODES     (INTERVAL_CODES)
  ) osc_table (
    .limit_tbl (osc_limit)
  );

  overflow_limit_table #(
    .CNT_WIDTH (CNT_WIDTH),
    .BASE_EXP  (X1_BASE_EXP),
    .CODES     (INTERVAL_CODES)
  ) x1_table (
    .limit_tbl (x1_limit)
  );

  // Register access decode
  always_comb begin
    mode_hit = 1'b0;
    key_hit  = 1'b0;
    if (bus_req.addr == MODE_ADDR) begin
      mode_hit = 1'b1;
    end else if (bus_req.addr == CLEAR_KEY_ADDR) begin
      key_hit = 1'b1;
    end
    mode_wr = bus_req.wr && mode_hit;
    mode_rd = bus_req.rd && mode_hit;
    key_wr  = bus_req.wr && key_hit;
    key_rd  = bus_req.rd && key_hit;
  end

  // Read data selection
  always_comb begin
    if (mode_rd) begin
      read_value = st_reg.mode;
    end else if (key_rd) begin
      read_value = CLEAR_KEY_READ;
    end else begin
      read_value = 8'h00;
    end
  end

  // Access violations
  always_comb begin
    mode_again    = mode_wr && st_reg.mode_written;
    mode_bit      = mode_wr && bus_req.bit_op;
    key_bad_value = key_wr && !bus_req.bit_op && (bus_req.wdata != CLEAR_KEY_VALUE);
    key_bit       = key_wr && bus_req.bit_op;
    violation     = mode_again || mode_bit || key_bad_value || key_bit;
  end

  // Clock source and overflow threshold
  always_comb begin
    // Strap is used live on the first edge, registered afterwards
    if (st_reg.opt_valid) begin
      stoppable_eff = st_reg.stoppable;
    end else begin
      stoppable_eff = osc_stoppable_opt;
    end
    // Fixed option forces oscillator and cannot stop
    use_x1 = stoppable_eff && st_reg.mode[CLOCK_SRC_POS];
    // Clock is gated in standby and while the source is down
    if (clk_stat.standby) begin
      src_running = 1'b0;
    end else if (use_x1) begin
      src_running = clk_stat.x1_run;
    end else begin
      src_running = clk_stat.osc_run;
    end
    if (use_x1) begin
      src_tick = src_running && x1_tick;
      limit    = x1_limit[st_reg.mode[INTERVAL_MSB:0]];
    end else begin
      src_tick = src_running && osc_tick;
      limit    = osc_limit[st_reg.mode[INTERVAL_MSB:0]];
    end
  end

  // Value stored on the one accepted mode write
  always_comb begin
    mode_stoppable_wr = {MODE_FIXED_HIGH, bus_req.wdata[CLOCK_STOP_POS:0]};
    // Clock field and upper bits are ignored here
    mode_fixed_wr     = {MODE_FIXED_HIGH, 2'h0, bus_req.wdata[INTERVAL_MSB:0]};
    stop_request      = stoppable_eff && bus_req.wdata[CLOCK_STOP_POS];
  end

  // Counter step and overflow
  always_comb begin
    count_step = src_tick && !st_reg.stopped;
    count_inc  = st_reg.count + CNT_WIDTH'(1);
    count_wrap = count_step && (count_inc >= limit);
  end

  // Violations fire at once, or wait for the source clock
  always_comb begin
    // Stopped watchdog drops violations for good
    fire_now     = violation && !st_reg.stopped && src_running;
    fire_later   = violation && !st_reg.stopped && !src_running;
    fire_pending = st_reg.pending && src_running && !st_reg.stopped;
  end

  always_comb begin
    st_next = st_reg;
    st_next.sys_reset = 1'b0;
    st_next.wait_pend = 1'b0;

    if (!st_reg.opt_valid) begin
      st_next.opt_valid = 1'b1;
      st_next.stoppable = osc_stoppable_opt;
    end

    if (cause_clear) begin
      st_next.cause_flag = 1'b0;
    end

    if (bus_req.rd) begin
      st_next.rdata = read_value;
    end

    if (count_step) begin
      st_next.count = count_inc;
    end

    if (count_wrap) begin
      st_next.sys_reset = 1'b1;
      st_next.count = '0;
    end

    if (mode_wr) begin
      st_next.wait_pend = 1'b1;
    end

    if (mode_wr && !violation) begin
      st_next.mode_written = 1'b1;
      st_next.count = '0;
      if (stoppable_eff) begin
        st_next.mode = mode_stoppable_wr;
      end else begin
        st_next.mode = mode_fixed_wr;
      end
      if (stop_request) begin
        st_next.stopped = 1'b1;
      end
    end

    if (key_wr && !violation) begin
      st_next.count = '0;
    end

    if (fire_now) begin
      st_next.sys_reset = 1'b1;
    end

    if (fire_later) begin
      st_next.pending = 1'b1;
    end

    if (fire_pending) begin
      st_next.pending = 1'b0;
      st_next.sys_reset = 1'b1;
    end

    // Set wins over a clear in the same cycle
    if (st_reg.sys_reset) begin
      st_next.cause_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg.opt_valid    <= 1'b0;
      st_reg.stoppable    <= 1'b0;
      st_reg.mode         <= MODE_RESET;
      st_reg.mode_written <= 1'b0;
      st_reg.stopped      <= 1'b0;
      st_reg.count        <= '0;
      st_reg.pending      <= 1'b0;
      st_reg.sys_reset    <= 1'b0;
      st_reg.cause_flag   <= st_reg.cause_flag;
      st_reg.wait_pend    <= 1'b0;
      st_reg.rdata        <= 8'h00;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    rdata = st_reg.rdata;
    bus_wait = st_reg.wait_pend;
    internal_reset = st_reg.sys_reset;
    reset_cause_register = 8'h00;
    reset_cause_register[CAUSE_BIT_POS] = st_reg.cause_flag;
  end

endmodule : loop_detect_watchdog

module overflow_limit_table
  import loop_watchdog_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W,
  parameter int BASE_EXP  = OSC_BASE_EXP,
  parameter int CODES     = 1 << (INTERVAL_MSB + 1)
) (
  output logic [CNT_WIDTH-1:0] limit_tbl [CODES]
);
  import loop_watchdog_pkg::*;

  // One threshold per interval code, one power of two per step
  for (genvar i = 0; i < CODES; i++) begin : g_entry
    assign limit_tbl[i] = CNT_WIDTH'(1) << (BASE_EXP + i);
  end

endmodule : overflow_limit_table

/* loop_detect_watchdog_asserts.sv */
`timescale 1ns/1ps
module loop_watchdog_checker
  import loop_watchdog_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       osc_stoppable_opt,
  input wire bus_req_t   bus_req,
  input wire clk_stat_t  clk_stat,
  input wire logic [7:0] rdata,
  input wire logic       bus_wait,
  input wire logic       internal_reset,
  input wire logic [7:0] reset_cause_register
);
  import loop_watchdog_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_KEY_READ: assert property (clk_en && bus_req.rd && bus_req.addr == CLEAR_KEY_ADDR |=> rdata == 8'h9a)
    else $error("clear key read not 9a");
  AST_UNMAPPED: assert property (clk_en && bus_req.rd && bus_req.addr[15:1] != 15'h7fcc |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_WAIT: assert property (clk_en && bus_req.wr && bus_req.addr == MODE_ADDR |=> bus_wait)
    else $error("no wait after mode write");
  AST_WAIT_SRC: assert property (bus_wait |-> $past(bus_req.wr) && $past(bus_req.addr) == MODE_ADDR)
    else $error("wait without mode write");
  AST_PULSE: assert property (internal_reset |=> !internal_reset)
    else $error("internal reset longer than one cycle");
  AST_CAUSE_SET: assert property (internal_reset |=> reset_cause_register[4])
    else $error("cause flag not set");
  AST_CAUSE_ONLY: assert property (reset_cause_register[3:0] == 4'h0 && reset_cause_register[7:5] == 3'h0)
    else $error("stray cause bits");
  AST_BAD_KEY: assert property (clk_en && !osc_stoppable_opt && clk_stat.osc_run && !clk_stat.standby
    && bus_req.wr && bus_req.addr == CLEAR_KEY_ADDR && (bus_req.bit_op || bus_req.wdata != 8'hac)
    |=> internal_reset)
    else $error("bad key write without reset");
endmodule : loop_watchdog_checker
bind loop_detect_watchdog loop_watchdog_checker chk_i (.*);

/* test_loop_detect_watchdog.sv */
`timescale 1ns/1ps
module test_loop_detect_watchdog;
  import loop_watchdog_pkg::*;
  logic mclk, rst_n, strap, cause_clear, rd_d, bus_wait, internal_reset;
  logic [7:0] rdata, reset_cause_register, expq[$];
  bus_req_t req;
  clk_stat_t st;
  logic [31:0] lf = 32'h000139d5;
  int n_fail = 0, cmp_count = 0, n;
  loop_detect_watchdog DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .osc_stoppable_opt(strap),
    .bus_req(req), .clk_stat(st), .osc_tick(1'b1), .x1_tick(1'b1), .cause_clear(cause_clear),
    .rdata(rdata), .bus_wait(bus_wait), .internal_reset(internal_reset),
    .reset_cause_register(reset_cause_register));
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask : cyc
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task acc(input logic w, input logic b, input logic [15:0] a, input logic [7:0] d);
    req = '{wr: w, rd: !w, bit_op: b, addr: a, wdata: d};
    cyc(1);
    req = '0;
  endtask : acc
  task rdq(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(0, 0, a, 8'h00);
    cyc(1);
  endtask : rdq
  task rst(input logic s);
    strap = s;
    rst_n = 0;
    st = 3'b110;
    cyc(6);
    rst_n = 1;
  endtask : rst
  task waitrst(input int lim);
    n = 0;
    while (internal_reset !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : waitrst
  always @(posedge mclk) begin
    if (rd_d) chk(rdata, expq.pop_front());
    rd_d <= req.rd;
  end
  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end
  initial begin
    req = '0;
    rd_d = 0;
    cause_clear = 1;
    rst(0);
    cyc(1);
    cause_clear = 0;
    chk(reset_cause_register, 8'h00);
    rdq(MODE_ADDR, 8'h67);
    rdq(CLEAR_KEY_ADDR, 8'h9a);
    rdq(16'hff9a, 8'h00);
    acc(1, 0, MODE_ADDR, 8'h78);
    chk(bus_wait, 1);
    cyc(1);
    rdq(MODE_ADDR, 8'h60);
    cyc(1000);
    acc(1, 0, CLEAR_KEY_ADDR, 8'hac);
    waitrst(3000);
    chk(n >= 2045 && n <= 2052, 1);
    cyc(1);
    chk(reset_cause_register, 8'h10);
    for (int k = 0; k < 3; k++) begin
      rst(0);
      lf = lfsr_next(lf);
      if (k == 0) begin
        acc(1, 0, MODE_ADDR, 8'h67);
        cyc(1);
      end
      acc(1, k == 2, k ? CLEAR_KEY_ADDR : MODE_ADDR, k == 1 ? lf[7:0] ^ {7'h00, lf[7:0] == 8'hac} : (k ? 8'hac : 8'h67));
      chk(internal_reset, 1);
    end
    rst(0);
    st.osc_run = 0;
    acc(1, 0, CLEAR_KEY_ADDR, 8'h00);
    waitrst(20);
    chk(n, 20);
    st.osc_run = 1;
    waitrst(10);
    chk(n < 10, 1);
    rst(1);
    acc(1, 0, MODE_ADDR, 8'h70);
    cyc(1);
    acc(1, 0, CLEAR_KEY_ADDR, 8'h00);
    waitrst(3000);
    chk(n == 3000, 1);
    rst(1);
    acc(1, 0, MODE_ADDR, 8'h68);
    st.standby = 1;
    cyc(100);
    st.standby = 0;
    waitrst(9000);
    chk(n >= 8188 && n <= 8196, 1);
    print_verdict();
  end
endmodule : test_loop_detect_watchdog
